//--- hdl/prs_pkg.sv
/*
 * Constants for the host-side reset and suspend control block.
 * Assumes a single 250 MHz core clock and active-low reset inputs.
 */
package prs_pkg;
   localparam int unsigned CLK_PERIOD_PS    = 4000;
   // reset-release qualification: one clock so release is seen on a rising edge
   localparam int unsigned RELEASE_TIME_PS  = 4000;
   localparam int unsigned RELEASE_CYCLES   =
      (RELEASE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned STATE_W          = 16;
   localparam logic [15:0] STATE_RESET_VAL  = 16'h0000;
   localparam logic        PME_ENABLE_RESET = 1'b0;

   typedef enum logic [1:0] {
      PRS_RESET   = 2'b00,
      PRS_RUN     = 2'b01,
      PRS_SUSPEND = 2'b10
   } prs_mode_t;
endpackage

//--- hdl/prs_reset_ctrl.sv
/*
 * Reset, suspend protection and output-enable control for the host bus side.
 * Assumes all inputs are synchronous to clk; rst_n is the chip power-on reset
 * of the flip-flops only, the two documented resets are sampled inputs.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - global reset tri-states every output and returns registers to defaults
// - global reset holds everything, PME context included, in default state
// - suspend ignores global reset, keeps registers, outputs stay tri-stated
// - suspend ignores bus reset, keeps registers, outputs stay tri-stated
// - all host bus signals sampled on rising clock edge
// - bus reset tri-states outputs and resets state_out to defaults; pme enable keeps its value
// - during bus reset PME may be driven only when enabled
// - after bus reset release the block is in default operating state
module prs_reset_ctrl
   import prs_pkg::*;
#(
   parameter int unsigned DATA_W = STATE_W
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              global_power_on_reset_in_n,
   input  wire logic              host_bus_reset_in_n,
   input  wire logic              suspend_in,
   input  wire logic              wr_en,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              pme_enable_wr,
   input  wire logic              pme_enable_in,
   input  wire logic              pme_event,
   output logic [DATA_W-1:0]      state_out,
   output logic                   pme_enable,
   output logic                   out_enable,
   output logic                   pme_out_n,
   output logic                   pme_oe,
   output logic                   ready
);

   prs_mode_t         mode;
   prs_mode_t         next_mode;
   logic [DATA_W-1:0] next_state_out;
   logic              next_pme_enable;
   logic              next_out_enable;
   logic              next_pme_out_n;
   logic              next_pme_oe;
   logic              next_ready;
   logic              global_power_on_reset_in;
   logic              host_bus_reset_in;

   assign global_power_on_reset_in = !global_power_on_reset_in_n;
   assign host_bus_reset_in = !host_bus_reset_in_n;

   // only normal operation lets out_enable and ready go live; the spare code stays quiet
   function automatic logic prs_outputs_live(input prs_mode_t m);
      logic live;
      live = 1'b0;
      unique case (m)
         PRS_RESET:   live = 1'b0;
         PRS_RUN:     live = 1'b1;
         PRS_SUSPEND: live = 1'b0;
         default:     live = 1'b0;
      endcase
      return live;
   endfunction

   // mode: suspend outranks global reset, which outranks bus reset
   always_comb begin
      next_mode = PRS_RUN;
      if (suspend_in) begin
         // suspend wins over both resets so context outlives them
         next_mode = PRS_SUSPEND;
      end else if (global_power_on_reset_in) begin
         next_mode = PRS_RESET;
      end else if (host_bus_reset_in) begin
         next_mode = PRS_RESET;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= PRS_RESET;
      end else begin
         mode <= next_mode;
      end
   end

   // register contents: writes only land in normal operation
   always_comb begin
      next_state_out = state_out;
      if (suspend_in) begin
         next_state_out = state_out;
      end else if (global_power_on_reset_in || host_bus_reset_in) begin
         next_state_out = DATA_W'(STATE_RESET_VAL);
      end else if (wr_en) begin
         next_state_out = wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_out <= DATA_W'(STATE_RESET_VAL);
      end else begin
         state_out <= next_state_out;
      end
   end

   // wake enable: only the global reset clears it
   always_comb begin
      next_pme_enable = pme_enable;
      if (suspend_in) begin
         next_pme_enable = pme_enable;
      end else if (global_power_on_reset_in) begin
         next_pme_enable = PME_ENABLE_RESET;
      end else if (host_bus_reset_in) begin
         // bus reset keeps pme enable: that is the wake context
         next_pme_enable = pme_enable;
      end else if (pme_enable_wr) begin
         next_pme_enable = pme_enable_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pme_enable <= PME_ENABLE_RESET;
      end else begin
         pme_enable <= next_pme_enable;
      end
   end

   // wake pin: driven in normal and bus reset, never in suspend or global reset
   always_comb begin
      next_pme_oe = 1'b0;
      if (!suspend_in && !global_power_on_reset_in) begin
         next_pme_oe = pme_enable && pme_event;
      end
      next_pme_out_n = !next_pme_oe;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pme_out_n <= 1'b1;
         pme_oe    <= 1'b0;
      end else begin
         pme_out_n <= next_pme_out_n;
         pme_oe    <= next_pme_oe;
      end
   end

   always_comb begin
      next_out_enable = prs_outputs_live(next_mode);
      next_ready      = prs_outputs_live(next_mode);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_enable <= 1'b0;
         ready      <= 1'b0;
      end else begin
         out_enable <= next_out_enable;
         ready      <= next_ready;
      end
   end

   // each check except mode_pins_a looks one edge past the inputs that it qualifies
   mode_pins_a : assert property (@(posedge clk) disable iff (!rst_n)
      (mode != PRS_RUN) |-> !out_enable && !ready)
      else $error("pins live outside normal operation");

   global_power_on_reset_in_clears_a : assert property (@(posedge clk) disable iff (!rst_n)
      (global_power_on_reset_in && !suspend_in) |=> (state_out == DATA_W'(STATE_RESET_VAL)) && !out_enable)
      else $error("global reset did not clear state");

   global_power_on_reset_in_pme_a : assert property (@(posedge clk) disable iff (!rst_n)
      (global_power_on_reset_in && !suspend_in) |=> !pme_enable && !pme_oe && pme_out_n)
      else $error("global reset kept pme context");

   susp_global_power_on_reset_in_a : assert property (@(posedge clk) disable iff (!rst_n)
      (suspend_in && global_power_on_reset_in) |=> $stable(state_out) && $stable(pme_enable) && !out_enable
         && !pme_oe)
      else $error("suspend did not shield global reset");

   susp_host_bus_reset_in_a : assert property (@(posedge clk) disable iff (!rst_n)
      (suspend_in && host_bus_reset_in) |=> $stable(state_out) && $stable(pme_enable) && !out_enable
         && !pme_oe)
      else $error("suspend did not shield bus reset");

   susp_quiet_a : assert property (@(posedge clk) disable iff (!rst_n)
      suspend_in |=> !out_enable && !ready && !pme_oe && pme_out_n)
      else $error("outputs live during suspend");

   host_bus_reset_in_clears_a : assert property (@(posedge clk) disable iff (!rst_n)
      (host_bus_reset_in && !global_power_on_reset_in && !suspend_in) |=> (state_out == DATA_W'(STATE_RESET_VAL))
         && !out_enable && $stable(pme_enable))
      else $error("bus reset did not clear state");

   host_bus_reset_in_pme_off_a : assert property (@(posedge clk) disable iff (!rst_n)
      (host_bus_reset_in && !global_power_on_reset_in && !suspend_in && !pme_enable) |=> !pme_oe && pme_out_n)
      else $error("pme driven while disabled in bus reset");

   host_bus_reset_in_pme_on_a : assert property (@(posedge clk) disable iff (!rst_n)
      (host_bus_reset_in && !global_power_on_reset_in && !suspend_in && pme_enable && pme_event) |=> pme_oe && !pme_out_n)
      else $error("enabled pme not driven in bus reset");

   pme_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
      !pme_enable |=> !pme_oe && pme_out_n)
      else $error("pme driven without enable");

   release_ready_a : assert property (@(posedge clk) disable iff (!rst_n)
      ($past(host_bus_reset_in) && !host_bus_reset_in && !global_power_on_reset_in && !suspend_in) |=> ready && out_enable)
      else $error("not ready after bus reset release");

   run_ready_a : assert property (@(posedge clk) disable iff (!rst_n)
      (!host_bus_reset_in && !global_power_on_reset_in && !suspend_in) |=> ready && out_enable)
      else $error("not ready in normal operation");

   sample_wr_a : assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && !suspend_in && !global_power_on_reset_in && !host_bus_reset_in) |=> (state_out == $past(wr_data)))
      else $error("write not sampled on rising edge");

endmodule

`default_nettype wire

//--- verification/prs_host_model.sv
/* host side model: drives the global and bus resets from bench requests.
   assumes requests change at rising clk edges; adds one cycle of delay. */
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic boot_req,
   input  wire logic bus_req,
   output logic      global_power_on_reset_in_n,
   output logic      host_bus_reset_in_n
);
   logic next_glb_n;
   logic next_bus_n;
   always_comb begin
      next_glb_n = ~boot_req;
      next_bus_n = ~bus_req;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         global_power_on_reset_in_n <= 1'b0;
         host_bus_reset_in_n        <= 1'b0;
      end else begin
         global_power_on_reset_in_n <= next_glb_n;
         host_bus_reset_in_n        <= next_bus_n;
      end
   end
endmodule
`default_nettype wire

//--- verification/prs_reset_ctrl_tb.sv
/* bench for prs_reset_ctrl driven through the host reset model.
   assumes outputs follow sampled inputs one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module prs_reset_ctrl_tb;
   import prs_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, boot = 1'b1, busr = 1'b0, sus = 1'b0;
   logic wr_en = 1'b0, pwr = 1'b0, pin = 1'b0, pev = 1'b0;
   logic [15:0] wr_data = 16'h0000, st;
   logic pen, oe, pme_n, pme_oe, rdy, g_n, b_n;
   int failures = 0, total_checks = 0;
   logic [31:0] rows [3] = '{32'h1234_1234, 32'hFFFF_FFFF, 32'h0000_0000};
   always #2 clk = ~clk;
   prs_host_model u_host (.clk(clk), .rst_n(rst_n), .boot_req(boot), .bus_req(busr),
      .global_power_on_reset_in_n(g_n), .host_bus_reset_in_n(b_n));
   prs_reset_ctrl u_dut (.clk(clk), .rst_n(rst_n), .global_power_on_reset_in_n(g_n),
      .host_bus_reset_in_n(b_n), .suspend_in(sus), .wr_en(wr_en), .wr_data(wr_data),
      .pme_enable_wr(pwr), .pme_enable_in(pin), .pme_event(pev), .state_out(st),
      .pme_enable(pen), .out_enable(oe), .pme_out_n(pme_n), .pme_oe(pme_oe), .ready(rdy));
   task tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task ck(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [15:0] d);
      tk(1); wr_en <= 1'b1; wr_data <= d;
      tk(1); wr_en <= 1'b0; #1;
   endtask
   // pme enable load, then bus reset with an event pending
   task bus_pme(input logic en);
      tk(1); pwr <= 1'b1; pin <= en;
      tk(1); pwr <= 1'b0; pev <= 1'b1; busr <= 1'b1;
      tk(3); #1;
      ck("oe", 16'h0, {15'h0, oe});
      ck("state", 16'h0, st);
      ck("pme_oe", {15'h0, en}, {15'h0, pme_oe});
      ck("pme_n", {15'h0, ~en}, {15'h0, pme_n});
      ck("pme_en kept", {15'h0, en}, {15'h0, pen});
      tk(1); busr <= 1'b0; pev <= 1'b0;
      tk(3); #1;
      ck("ready", 16'h1, {15'h0, rdy});
      ck("oe on", 16'h1, {15'h0, oe});
      $display("bus reset test done");
   endtask
   task final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      tk(3); rst_n <= 1'b1;
      tk(2); boot <= 1'b0;
      tk(3);
      foreach (rows[i]) begin
         wr(rows[i][31:16]);
         ck("write", rows[i][15:0], st);
      end
      $display("row test done");
      bus_pme(1'b1);
      bus_pme(1'b0);
      wr(16'hA5A5);
      // wake enable set so suspend and global reset have context to act on
      tk(1);
      pwr <= 1'b1;
      pin <= 1'b1;
      tk(1);
      pwr <= 1'b0;
      #1;
      ck("pen load", 16'h1, {15'h0, pen});
      // suspend outranks both resets; registers must survive
      tk(1); sus <= 1'b1; boot <= 1'b1; busr <= 1'b1; pwr <= 1'b1; pin <= 1'b0;
      pev <= 1'b1;
      tk(3); #1;
      ck("sus state", 16'hA5A5, st);
      ck("sus oe", 16'h0, {15'h0, oe});
      ck("sus pme_en", 16'h1, {15'h0, pen});
      ck("sus pme_oe", 16'h0, {15'h0, pme_oe});
      tk(1); sus <= 1'b0; busr <= 1'b0; pwr <= 1'b0;
      pev <= 1'b0;
      tk(3); #1;
      ck("glb state", 16'h0, st);
      ck("glb pme_en", 16'h0, {15'h0, pen});
      ck("glb oe", 16'h0, {15'h0, oe});
      $display("suspend and global test done");
      final_report();
   end
endmodule
`default_nettype wire
